//--- hdl/uart_flags_and_data_buffer.sv
// Purpose: status flags, interrupt enables and data buffer of a uart
// Assumes: shift engines and bit sampling sit outside this block
// Notes: register port answers reads one cycle after the strobe
`default_nettype none

module uart_flags_and_data_buffer
  import uart_flags_pkg::*;
(
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic rst_b, // synchronous reset, low active
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic rx_char_done, // receiver completed a character
  input wire logic [8:0] rx_char, // received character bits
  input wire logic rx_noise, // noise seen in this character
  input wire logic rx_stop_zero, // stop bit accepted as zero
  input wire logic rx_parity_bad, // parity check failed
  input wire logic rx_break, // break character detected
  input wire logic rx_idle_char, // idle character detected
  input wire logic rx_line_ones, // ones seen on the receive line
  input wire logic rx_start_seen, // zero at start_sample_one
  input wire logic rx_false_start, // start bit rejected
  input wire logic tx_take, // shift register takes the character
  input wire logic tx_busy, // data, preamble or break shifting
  input wire logic tx_queued, // preamble or break queued
  output logic [8:0] tx_char, // character for the shift register
  output logic tx_char_valid, // buffer holds an unsent character
  output logic nine_bit_mode, // char_nine_bit_select to engines
  output logic rx_on, // rx_enable to the receiver
  output logic irq_tx, // transmitter interrupt request
  output logic irq_rx, // receiver interrupt request
  output logic irq_err // error interrupt request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_main_reg; // module enable, format
  logic [7:0] ctrl_irq_reg; // irq enables, rx enable
  logic [3:0] err_en_reg; // overrun, noise, framing, parity enables
  logic tx_ninth_reg; // ninth bit to transmit
  logic rx_ninth_reg; // ninth bit received
  logic [7:0] rx_buf_reg; // received data
  logic [7:0] tx_buf_reg; // data to transmit
  logic [8:0] tx_char_reg; // character handed to the shifter
  logic [7:0] pri_reg; // primary flags
  logic brk_reg; // break flag
  logic act_reg; // reception in progress
  logic [7:0] arm_reg; // primary flags seen at last status read
  logic brk_arm_reg; // break seen at last secondary read
  logic idle_ok_reg; // a character has armed the idle flag
  logic brk_ok_reg; // line showed ones since last break
  logic [7:0] rdata_reg; // read data register
  logic [7:0] pri_next; // next primary flags
  logic [7:0] rd_mux; // read data select

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic dat_rd; // data buffer read
  logic dat_wr; // data buffer write
  logic pri_rd; // primary status read
  logic sec_rd; // secondary status read
  logic mod_en; // module enabled
  logic rx_ok; // receiver events accepted
  logic rx_any; // character or break arrived
  logic rx_load; // buffer takes the new character
  logic ovr_set; // overrun this cycle
  logic [5:0] clr_rx; // receiver flags cleared this cycle
  logic txe_clr; // tx empty cleared this cycle
  logic take_ok; // handoff to the shifter

  assign dat_rd = rd & hit(addr, OFF_DATA_BUF);
  assign dat_wr = wr & hit(addr, OFF_DATA_BUF);
  assign pri_rd = rd & hit(addr, OFF_PRI_STATUS);
  assign sec_rd = rd & hit(addr, OFF_SEC_STATUS);
  assign mod_en = ctrl_main_reg[B_MOD_EN];
  assign rx_ok = ctrl_irq_reg[B_RX_EN];
  assign rx_any = rx_ok & (rx_char_done | rx_break);
  // clear only flags that were seen set at the status read
  assign clr_rx = dat_rd ? arm_reg[5:0] : 6'h00;
  assign txe_clr = dat_wr & arm_reg[B_TXE];
  // a character that lands while the buffer is full is dropped
  assign ovr_set = rx_ok & rx_char_done & pri_reg[B_RXF]
                   & ~clr_rx[B_RXF];
  assign rx_load = rx_any & ~ovr_set & ~(rx_break & pri_reg[B_RXF]
                   & ~clr_rx[B_RXF]);
  assign take_ok = tx_take & ~pri_reg[B_TXE] & mod_en;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // main control: module enable and character length
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_main_reg <= RST_ZERO;
    end else if (ce && wr && hit(addr, OFF_CTRL_MAIN)) begin
      ctrl_main_reg <= wdata;
    end
  end

  // irq control; rx enable may change only with the module enabled
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_irq_reg <= RST_ZERO;
    end else if (ce && wr && hit(addr, OFF_CTRL_IRQ)) begin
      ctrl_irq_reg <= wdata;
      if (!mod_en) begin
        ctrl_irq_reg[B_RX_EN] <= ctrl_irq_reg[B_RX_EN];
      end
    end
  end

  // error control: enables and transmit ninth bit reset to zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      err_en_reg <= 4'h0;
      tx_ninth_reg <= 1'b0;
    end else if (ce && wr && hit(addr, OFF_RX_ERR_CTRL)) begin
      err_en_reg <= {wdata[B_OR_IE], wdata[B_NE_IE], wdata[B_FE_IE],
                     wdata[B_PE_IE]};
      tx_ninth_reg <= wdata[B_T8];
    end
  end

  // ----------------------------------------------------------------
  // data storage, buffers not touched by reset, shifter character reset to zero
  // ----------------------------------------------------------------
  // receive side: buffer and ninth bit load together
  always_ff @(posedge clk_sys) begin
    if (ce && rx_load) begin
      if (rx_break) begin
        rx_buf_reg <= RST_ZERO;
        rx_ninth_reg <= 1'b0;
      end else begin
        rx_buf_reg <= rx_char[7:0];
        // nine-bit mode keeps bit 8, otherwise a copy of bit 7
        rx_ninth_reg <= nine_bit_mode ? rx_char[8] : rx_char[7];
      end
    end
  end

  // transmit side: separate storage at the same address
  always_ff @(posedge clk_sys) begin
    if (ce && dat_wr) begin
      tx_buf_reg <= wdata;
    end
  end

  // character handed to the shifter with its ninth bit
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_char_reg <= 9'h000;
    end else if (ce && take_ok) begin
      tx_char_reg <= {nine_bit_mode & tx_ninth_reg, tx_buf_reg};
    end
  end

  // ----------------------------------------------------------------
  // primary flags
  // ----------------------------------------------------------------
  // set wins over clear for every flag
  always_comb begin
    pri_next = pri_reg;
    // tx empty: set on handoff, forced while disabled
    pri_next[B_TXE] = ~mod_en | take_ok
                      | (pri_reg[B_TXE] & ~txe_clr);
    // tx done: empty and nothing shifting or queued
    pri_next[B_TXD] = ~mod_en | (pri_reg[B_TXE] & ~tx_busy
                      & ~tx_queued);
    pri_next[B_RXF] = rx_any | (pri_reg[B_RXF] & ~clr_rx[B_RXF]);
    pri_next[B_IDL] = (rx_ok & rx_idle_char & idle_ok_reg)
                      | (pri_reg[B_IDL] & ~clr_rx[B_IDL]);
    pri_next[B_OVR] = ovr_set
                      | (pri_reg[B_OVR] & ~clr_rx[B_OVR]);
    pri_next[B_NSE] = (rx_ok & rx_char_done & rx_noise)
                      | (pri_reg[B_NSE] & ~clr_rx[B_NSE]);
    pri_next[B_FRM] = (rx_ok & ((rx_char_done & rx_stop_zero) | rx_break))
                      | (pri_reg[B_FRM] & ~clr_rx[B_FRM]);
    pri_next[B_PAR] = (rx_ok & rx_char_done & rx_parity_bad)
                      | (pri_reg[B_PAR] & ~clr_rx[B_PAR]);
  end

  // primary flag register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pri_reg <= RST_PRI_STATUS;
    end else if (ce) begin
      pri_reg <= pri_next;
    end
  end

  // snapshot of flags seen by each status read
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      arm_reg <= RST_ZERO;
      brk_arm_reg <= 1'b0;
    end else if (ce) begin
      if (pri_rd) begin
        arm_reg <= pri_reg;
      end else if (dat_rd) begin
        arm_reg[5:0] <= 6'h00;
      end else if (dat_wr) begin
        arm_reg[B_TXE] <= 1'b0;
      end
      if (sec_rd) begin
        brk_arm_reg <= brk_reg;
      end else if (dat_rd) begin
        brk_arm_reg <= 1'b0;
      end
    end
  end

  // idle flag may set only after a character since enable or clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      idle_ok_reg <= 1'b0;
    end else if (ce) begin
      if (!rx_ok || (pri_reg[B_IDL] && clr_rx[B_IDL])) begin
        idle_ok_reg <= 1'b0;
      end else if (rx_any) begin
        idle_ok_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // secondary flags
  // ----------------------------------------------------------------
  // break flag with rearm on ones
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      brk_reg <= 1'b0;
      brk_ok_reg <= 1'b1;
    end else if (ce) begin
      if (rx_ok && rx_break && brk_ok_reg) begin
        brk_reg <= 1'b1;
        brk_ok_reg <= 1'b0;
      end else begin
        if (dat_rd && brk_arm_reg) begin
          brk_reg <= 1'b0;
        end
        if (rx_ok && rx_line_ones) begin
          brk_ok_reg <= 1'b1;
        end
      end
    end
  end

  // reception in progress
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      act_reg <= 1'b0;
    end else if (ce && rx_ok) begin
      if (rx_start_seen) begin
        act_reg <= 1'b1;
      end else if (rx_false_start || rx_idle_char) begin
        act_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data select by address
  always_comb begin
    case (addr)
      OFF_CTRL_MAIN: rd_mux = ctrl_main_reg;
      OFF_CTRL_IRQ: rd_mux = ctrl_irq_reg;
      OFF_RX_ERR_CTRL: rd_mux = {rx_ninth_reg, tx_ninth_reg, 2'b00,
                                 err_en_reg};
      OFF_PRI_STATUS: rd_mux = pri_reg;
      OFF_SEC_STATUS: rd_mux = {6'h00, brk_reg, act_reg};
      OFF_DATA_BUF: rd_mux = rx_buf_reg;
      default: rd_mux = RD_UNMAPPED;
    endcase
  end

  // read data stands for one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_reg <= RST_ZERO;
    end else if (ce) begin
      rdata_reg <= rd ? rd_mux : RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_reg;
  assign tx_char = tx_char_reg;
  assign tx_char_valid = ~pri_reg[B_TXE] & mod_en;
  assign nine_bit_mode = ctrl_main_reg[B_NINE];
  assign rx_on = rx_ok;
  // level requests, held while an enabled flag stays set; irq_tx also needs the module enabled
  assign irq_tx = mod_en & ((pri_reg[B_TXE] & ctrl_irq_reg[B_TXE_IE])
                  | (pri_reg[B_TXD] & ctrl_irq_reg[B_TXD_IE]));
  assign irq_rx = (pri_reg[B_RXF] & ctrl_irq_reg[B_RXF_IE])
                  | (pri_reg[B_IDL] & ctrl_irq_reg[B_IDL_IE]);
  assign irq_err = |(pri_reg[3:0] & err_en_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_rx_full_set: assert property (ce && rx_ok && rx_char_done |=>
    pri_reg[B_RXF]) else $error("rx full not set");
  a_overrun_keeps: assert property (ce && ovr_set |=>
    pri_reg[B_OVR] && rx_buf_reg == $past(rx_buf_reg))
    else $error("overrun lost flag or data");
  a_overrun_unseen: assert property (ce && dat_rd && !arm_reg[B_OVR]
    && pri_reg[B_OVR] |=> pri_reg[B_OVR])
    else $error("unseen overrun cleared");
  a_tx_empty_clr: assert property (ce && mod_en && dat_wr
    && arm_reg[B_TXE] && !take_ok |=> !pri_reg[B_TXE])
    else $error("tx empty not cleared");
  a_tx_done_drop: assert property (ce && mod_en && tx_busy
    |=> !pri_reg[B_TXD]) else $error("tx done while busy");
  a_mod_off_irq: assert property (!mod_en |-> !irq_tx)
    else $error("tx irq while disabled");
  a_err_irq_or: assert property (pri_reg[B_OVR] && err_en_reg[3]
    |-> irq_err) else $error("overrun irq missing");
  a_break_sets: assert property (ce && rx_ok && rx_break
    |=> pri_reg[B_FRM] && pri_reg[B_RXF])
    else $error("break did not set flags");
  a_idle_gate: assert property (ce && !idle_ok_reg && !pri_reg[B_IDL]
    |=> !pri_reg[B_IDL]) else $error("idle set before character");
  a_rx_off_hold: assert property (ce && !rx_ok && !dat_rd
    |=> pri_reg[5:0] == $past(pri_reg[5:0]))
    else $error("rx flags changed while off");
  a_read_data: assert property (ce && pri_rd ##1 ce
    |-> rdata == $past(pri_reg)) else $error("status read wrong");

  c_overrun: cover property (ce && ovr_set);
  c_full_clear: cover property (ce && pri_rd && pri_reg[B_RXF]
    ##[1:8] ce && dat_rd ##1 !pri_reg[B_RXF]);
  c_break: cover property (ce && rx_ok && rx_break && brk_ok_reg);

endmodule

`default_nettype wire

//--- hdl/uart_flags_pkg.sv
// Purpose: constants for the serial flags and data buffer block
// Assumes: 8-bit register port, offsets are byte addresses
// Notes: bit positions index into 8-bit register images
`default_nettype none

package uart_flags_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_MAIN = 8'h10; // enable and format
  localparam logic [7:0] OFF_CTRL_IRQ = 8'h11; // irq enables, rx on
  localparam logic [7:0] OFF_RX_ERR_CTRL = 8'h12; // ninth bits, err en
  localparam logic [7:0] OFF_PRI_STATUS = 8'h13; // primary flags
  localparam logic [7:0] OFF_SEC_STATUS = 8'h14; // break, rx active
  localparam logic [7:0] OFF_DATA_BUF = 8'h18; // rx / tx data

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_MOD_EN = 0; // main control: module_enable
  localparam int B_NINE = 1; // main control: char_nine_bit_select
  localparam int B_TXE_IE = 7; // irq control: tx_empty_irq_en
  localparam int B_TXD_IE = 6; // irq control: tx_done_irq_en
  localparam int B_RXF_IE = 5; // irq control: rx_full_irq_en
  localparam int B_IDL_IE = 4; // irq control: idle_irq_en
  localparam int B_RX_EN = 2; // irq control: rx_enable
  localparam int B_R8 = 7; // error control: rx_ninth_bit
  localparam int B_T8 = 6; // error control: tx_ninth_bit
  localparam int B_OR_IE = 3; // error control: overrun_irq_en
  localparam int B_NE_IE = 2; // error control: noise_irq_en
  localparam int B_FE_IE = 1; // error control: framing_irq_en
  localparam int B_PE_IE = 0; // error control: parity_irq_en
  localparam int B_TXE = 7; // primary: tx_empty_flag
  localparam int B_TXD = 6; // primary: tx_done_flag
  localparam int B_RXF = 5; // primary: rx_full_flag
  localparam int B_IDL = 4; // primary: idle flag
  localparam int B_OVR = 3; // primary: rx_overrun_flag
  localparam int B_NSE = 2; // primary: noise_flag
  localparam int B_FRM = 1; // primary: framing_error_flag
  localparam int B_PAR = 0; // primary: parity_error_flag
  localparam int B_BRK = 1; // secondary: break_flag
  localparam int B_ACT = 0; // secondary: rx_active_flag

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PRI_STATUS = 8'hc0; // tx empty and done
  localparam logic [7:0] RST_ZERO = 8'h00; // cleared registers
  localparam logic [7:0] RD_UNMAPPED = 8'h00; // unmapped reads

endpackage

`default_nettype wire

//--- bench/uart_far_end.sv
// Purpose: far-side model of the receive and transmit engines
// Assumes: the bench drives it through its tasks and knobs
// Notes: released qualifiers show the inverse of their last value
`default_nettype none

module uart_far_end
  import uart_flags_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic tx_char_valid, // buffer holds a character
  output logic rx_char_done = 1'b0, // character complete
  output logic [8:0] rx_char = 9'h000, // received bits
  output logic rx_noise = 1'b0, // noise seen
  output logic rx_stop_zero = 1'b0, // zero stop bit
  output logic rx_parity_bad = 1'b0, // parity failed
  output logic rx_break = 1'b0, // break seen
  output logic rx_idle_char = 1'b0, // idle character seen
  output logic rx_line_ones = 1'b0, // ones on the line
  output logic rx_start_seen = 1'b0, // start bit zero
  output logic rx_false_start = 1'b0, // start bit rejected
  output logic tx_take, // shifter takes the character
  output logic tx_busy, // shifting out
  output logic tx_queued = 1'b0 // preamble or break queued
);
  timeunit 1ns;
  timeprecision 1ps;
  bit take_en; // shifter may take characters
  int take_wait; // cycles before a take, slow or prompt
  int busy_len; // cycles spent shifting

  // ---------------------------------------------
  // receiver events, one pulse each
  // ---------------------------------------------
  task rx_evt(input logic [5:0] ev, input logic [8:0] ch,
              input logic [2:0] err);
    @(posedge clk_sys);
    {rx_char_done, rx_break, rx_idle_char} <= ev[5:3];
    {rx_line_ones, rx_start_seen, rx_false_start} <= ev[2:0];
    rx_char <= ch;
    {rx_noise, rx_stop_zero, rx_parity_bad} <= err;
    @(posedge clk_sys);
    {rx_char_done, rx_break, rx_idle_char} <= 3'h0;
    {rx_line_ones, rx_start_seen, rx_false_start} <= 3'h0;
    // stale qualifiers flip so nothing leans on old values
    rx_char <= ~ch;
    {rx_noise, rx_stop_zero, rx_parity_bad} <= ~err;
  endtask

  // queues a preamble or break, held until released
  task hold_queued(input logic v);
    @(posedge clk_sys);
    tx_queued <= v;
  endtask

  // ---------------------------------------------
  // transmit shifter: take, then shift a while
  // ---------------------------------------------
  initial begin
    {tx_take, tx_busy} = 2'h0;
    take_en = 1'b0;
    take_wait = 0;
    busy_len = 4;
    forever begin
      @(posedge clk_sys);
      if (take_en && tx_char_valid === 1'b1) begin
        repeat (take_wait) @(posedge clk_sys);
        tx_take <= 1'b1;
        @(posedge clk_sys);
        tx_take <= 1'b0;
        tx_busy <= 1'b1;
        repeat (busy_len) @(posedge clk_sys);
        tx_busy <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

//--- bench/tb_uart_flags_and_data_buffer.sv
// Purpose: self-checking bench for the uart flags and data buffer
// Assumes: far-side engines come from uart_far_end
// Notes: each read notes its expectation; a monitor compares later
`default_nettype none

module tb_uart_flags_and_data_buffer import uart_flags_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  localparam logic [5:0] EV_CHAR = 6'h20; // character done
  localparam logic [5:0] EV_BRK = 6'h10; // break
  localparam logic [5:0] EV_IDLE = 6'h08; // idle character
  localparam logic [5:0] EV_ONES = 6'h04; // ones on line
  localparam logic [5:0] EV_START = 6'h02; // start bit zero
  localparam logic [5:0] EV_FALSE = 6'h01; // false start
  logic clk_sys, rst_b, ce, wr, rd, rd_q, m;
  logic [7:0] addr, wdata, rdata;
  logic rx_char_done, rx_noise, rx_stop_zero, rx_parity_bad, rx_break;
  logic rx_idle_char, rx_line_ones, rx_start_seen, rx_false_start;
  logic tx_take, tx_busy, tx_queued, tx_char_valid, nine_bit_mode;
  logic rx_on, irq_tx, irq_rx, irq_err;
  logic [8:0] rx_char, tx_char, d;
  logic [15:0] exp_q[$]; // {mask, expected} per read
  logic [15:0] note;
  int failures, num_checks, i;
  integer seed;

  uart_flags_and_data_buffer i_dut (.clk_sys, .rst_b, .ce, .addr,
    .wdata, .wr, .rd, .rdata, .rx_char_done, .rx_char, .rx_noise,
    .rx_stop_zero, .rx_parity_bad, .rx_break, .rx_idle_char,
    .rx_line_ones, .rx_start_seen, .rx_false_start, .tx_take, .tx_busy,
    .tx_queued, .tx_char, .tx_char_valid, .nine_bit_mode, .rx_on,
    .irq_tx, .irq_rx, .irq_err);
  uart_far_end i_far (.clk_sys, .tx_char_valid, .rx_char_done,
    .rx_char, .rx_noise, .rx_stop_zero, .rx_parity_bad, .rx_break,
    .rx_idle_char, .rx_line_ones, .rx_start_seen, .rx_false_start,
    .tx_take, .tx_busy, .tx_queued);

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task print_verdict();
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read, noting the masked value the monitor must see
  task rd_exp(input logic [7:0] a, input logic [7:0] mk,
              input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({mk, e});
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  task chk_irq(input logic [2:0] e);
    #1 check({6'h0, irq_tx, irq_rx, irq_err}, {6'h0, e});
  endtask

  task wait_taken();
    int n;
    for (n = 0; n < 60 && tx_char_valid !== 1'b0; n++) @(posedge clk_sys);
    if (n == 60) begin
      failures++;
      print_verdict();
    end
  endtask

  // ---------------------------------------------
  // monitor: read data stands the cycle after rd
  // ---------------------------------------------
  always @(posedge clk_sys) begin
    if (rd_q) begin
      note = exp_q.pop_front();
      if (note[15:8] != 8'h00)
        check({1'b0, rdata & note[15:8]}, {1'b0, note[7:0]});
    end
    rd_q <= rd;
  end

  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {rst_b, wr, rd} = 3'h0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    seed = 58838;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    // reset values, unmapped place, refused rx enable
    chk_irq(3'b000);
    rd_exp(OFF_PRI_STATUS, 8'hff, RST_PRI_STATUS);
    rd_exp(OFF_SEC_STATUS, 8'hff, RST_ZERO);
    rd_exp(OFF_RX_ERR_CTRL, 8'h7f, RST_ZERO);
    rd_exp(8'h20, 8'hff, RD_UNMAPPED);
    wr_reg(OFF_CTRL_IRQ, 8'h04);
    rd_exp(OFF_CTRL_IRQ, 8'hff, RST_ZERO);
    wr_reg(OFF_CTRL_MAIN, 8'h01);
    wr_reg(OFF_CTRL_IRQ, 8'hf4);
    rd_exp(OFF_CTRL_IRQ, 8'hff, 8'hf4);
    chk_irq(3'b100);
    // reception flag, and idle not armed before a character
    i_far.rx_evt(EV_START, 9'h000, 3'h0);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h01);
    i_far.rx_evt(EV_FALSE, 9'h000, 3'h0);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h00);
    i_far.rx_evt(EV_START, 9'h000, 3'h0);
    i_far.rx_evt(EV_IDLE, 9'h000, 3'h0);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h00);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    // random characters in both character sizes
    for (i = 0; i < 4; i++) begin
      m = i[0];
      wr_reg(OFF_CTRL_MAIN, {6'h0, m, 1'b1});
      #1 check({8'h0, nine_bit_mode}, {8'h0, m});
      d = 9'($random(seed));
      i_far.rx_evt(EV_CHAR, d, 3'h0);
      chk_irq(3'b110);
      rd_exp(OFF_PRI_STATUS, 8'hff, 8'he0);
      rd_exp(OFF_DATA_BUF, 8'hff, d[7:0]);
      rd_exp(OFF_RX_ERR_CTRL, 8'h80, {m ? d[8] : d[7], 7'h0});
      rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
      chk_irq(3'b100);
    end
    // idle sets once, then needs a new character
    i_far.rx_evt(EV_IDLE, 9'h000, 3'h0);
    chk_irq(3'b110);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hd0);
    rd_exp(OFF_DATA_BUF, 8'h00, 8'h00);
    i_far.rx_evt(EV_IDLE, 9'h000, 3'h0);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    // overrun, plain and between the two reads
    wr_reg(OFF_RX_ERR_CTRL, 8'h08);
    i_far.rx_evt(EV_CHAR, 9'h011, 3'h0);
    i_far.rx_evt(EV_CHAR, 9'h022, 3'h0);
    chk_irq(3'b111);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'he8);
    rd_exp(OFF_DATA_BUF, 8'hff, 8'h11);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    i_far.rx_evt(EV_CHAR, 9'h033, 3'h0);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'he0);
    i_far.rx_evt(EV_CHAR, 9'h044, 3'h0);
    rd_exp(OFF_DATA_BUF, 8'hff, 8'h33);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc8);
    rd_exp(OFF_DATA_BUF, 8'hff, 8'h33);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    // parity, framing and noise, each gated by its own enable
    for (i = 0; i < 3; i++) begin
      wr_reg(OFF_RX_ERR_CTRL, {4'h0, 4'hf & ~(4'h1 << i)});
      i_far.rx_evt(EV_CHAR, 9'h05a, 3'h1 << i);
      chk_irq(3'b110);
      wr_reg(OFF_RX_ERR_CTRL, {4'h0, 4'h1 << i});
      chk_irq(3'b111);
      rd_exp(OFF_PRI_STATUS, 8'hff, 8'he0 | (8'h01 << i));
      rd_exp(OFF_DATA_BUF, 8'hff, 8'h5a);
      rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    end
    // receiver off keeps its flags and ignores characters
    i_far.rx_evt(EV_CHAR, 9'h055, 3'h0);
    wr_reg(OFF_CTRL_IRQ, 8'hf0);
    #1 check({8'h0, rx_on}, 9'h000);
    i_far.rx_evt(EV_CHAR, 9'h066, 3'h0);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'he0);
    rd_exp(OFF_DATA_BUF, 8'hff, 8'h55);
    wr_reg(OFF_CTRL_IRQ, 8'hf4);
    // break in nine-bit mode, clearing and rearming
    wr_reg(OFF_CTRL_MAIN, 8'h03);
    i_far.rx_evt(EV_CHAR, 9'h1ff, 3'h0);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'he0);
    rd_exp(OFF_DATA_BUF, 8'hff, 8'hff);
    i_far.rx_evt(EV_BRK, 9'h000, 3'h0);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h02);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'he2);
    rd_exp(OFF_RX_ERR_CTRL, 8'h80, 8'h00);
    rd_exp(OFF_DATA_BUF, 8'hff, 8'h00);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h00);
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    i_far.rx_evt(EV_BRK, 9'h000, 3'h0);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h00);
    rd_exp(OFF_PRI_STATUS, 8'h00, 8'h00);
    rd_exp(OFF_DATA_BUF, 8'h00, 8'h00);
    i_far.rx_evt(EV_ONES, 9'h000, 3'h0);
    i_far.rx_evt(EV_BRK, 9'h000, 3'h0);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h02);
    rd_exp(OFF_PRI_STATUS, 8'h00, 8'h00);
    rd_exp(OFF_DATA_BUF, 8'h00, 8'h00);
    rd_exp(OFF_SEC_STATUS, 8'hff, 8'h00);
    // clock enable low freezes all state, events are lost
    ce <= 1'b0;
    i_far.rx_evt(EV_CHAR, 9'h077, 3'h0);
    ce <= 1'b1;
    rd_exp(OFF_PRI_STATUS, 8'hff, 8'hc0);
    // transmit random characters, prompt and slow takes
    for (i = 0; i < 4; i++) begin
      m = i[0];
      d = 9'($random(seed));
      wr_reg(OFF_CTRL_MAIN, {6'h0, m, 1'b1});
      wr_reg(OFF_RX_ERR_CTRL, {1'b0, d[8], 6'h0});
      rd_exp(OFF_PRI_STATUS, 8'hc0, 8'hc0);
      wr_reg(OFF_DATA_BUF, d[7:0]);
      rd_exp(OFF_PRI_STATUS, 8'hc0, 8'h00);
      chk_irq(3'b000);
      i_far.take_wait = i * 3;
      i_far.take_en = 1'b1;
      wait_taken();
      #1 check(tx_char, {m & d[8], d[7:0]});
      rd_exp(OFF_PRI_STATUS, 8'hc0, 8'h80);
      i_far.take_en = 1'b0;
      repeat (8) @(posedge clk_sys);
      rd_exp(OFF_PRI_STATUS, 8'hc0, 8'hc0);
    end
    // a queued preamble or break drops the done flag
    i_far.hold_queued(1'b1);
    rd_exp(OFF_PRI_STATUS, 8'hc0, 8'h80);
    i_far.hold_queued(1'b0);
    rd_exp(OFF_PRI_STATUS, 8'hc0, 8'hc0);
    // module disable with a character pending
    rd_exp(OFF_PRI_STATUS, 8'hc0, 8'hc0);
    wr_reg(OFF_DATA_BUF, 8'haa);
    wr_reg(OFF_CTRL_MAIN, 8'h00);
    rd_exp(OFF_PRI_STATUS, 8'hc0, 8'hc0);
    chk_irq(3'b000);
    #1 check({8'h0, tx_char_valid}, 9'h000);
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0) failures++;
    print_verdict();
  end
endmodule

`default_nettype wire
